//--- bench/rtw_checker.sv
// Checker of watchdog, interrupt 5 and read-clear timing.
// Assumes it is bound to rtw_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Checker
module rtw_checker #(
    parameter int WDOG_CYC = 64
) (
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire logic                       i_arvalid,
    input wire logic                       o_arready,
    input wire logic [rtw_pkg::ADDR_W-1:0] i_araddr,
    input wire logic                       o_rvalid,
    input wire logic [31:0]                o_rdata,
    input wire logic [1:0]                 o_rresp,
    input wire logic                       o_ext_int5,
    input wire logic                       o_chip_reset
);
    int   hi_cnt;
    logic fired;
    wire  rd_int5 = i_arvalid && o_arready && (i_araddr == rtw_pkg::OFF_INT5);
    // Cycles the request has stood, and whether reset fired meanwhile
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_ext_int5) begin
            hi_cnt <= 0;
            fired  <= 1'b0;
        end else begin
            hi_cnt <= hi_cnt + 1;
            fired  <= fired | o_chip_reset;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rst_pulse; o_chip_reset |=> !o_chip_reset; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    property p_rst_early; o_chip_reset |-> hi_cnt >= WDOG_CYC - 3; endproperty
    a_rst_early: assert property (p_rst_early) else $error("reset too early");
    property p_rst_late; hi_cnt == WDOG_CYC + 4 |-> fired; endproperty
    a_rst_late: assert property (p_rst_late) else $error("reset missing");
    property p_rst_irq; o_chip_reset |-> o_ext_int5 && $past(o_ext_int5); endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("reset without request");
    property p_rd_clr; rd_int5 && !o_chip_reset |-> ##2 !o_ext_int5; endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("flag not cleared by read");
    property p_rd_old; rd_int5 && o_ext_int5 |=> o_rvalid && o_rdata[5:4] == 2'h3; endproperty
    a_rd_old: assert property (p_rd_old) else $error("read lost flag");
    property p_serv; rd_int5 |-> ##3 !o_chip_reset [*4]; endproperty
    a_serv: assert property (p_serv) else $error("reset after service");
    property p_unmap; i_arvalid && o_arready && i_araddr == 16'h0000 |=> o_rresp == 2'h3; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    c_fire: cover property (o_chip_reset);
    c_rise: cover property ($rose(o_ext_int5));
    c_read: cover property (rd_int5 && o_ext_int5);
endmodule
`default_nettype wire

//--- bench/rtw_core_model.sv
// Model of the core interrupt 5 input and the system reset logic.
// Assumes a level request and a one-cycle reset request.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Core side
module rtw_core_model (
    input  wire logic i_clk,
    input  wire logic i_ext_int5,
    input  wire logic i_chip_reset,
    output var int    o_irq_rises,
    output var int    o_resets
);
    logic int5_q = 1'b0;
    int   rises_q = 0, resets_q = 0;
    assign o_irq_rises = rises_q;
    assign o_resets = resets_q;
    always @(posedge i_clk) begin
        int5_q <= i_ext_int5;
        if (i_ext_int5 && !int5_q) rises_q <= rises_q + 1;
        if (i_chip_reset) resets_q <= resets_q + 1;
    end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Testbench of the clock block over its register bus.
// Assumes rtw_pkg, rtw_top, rtw_checker and rtw_core_model compiled first.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Bench
module tb_top;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_lsosc = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [15:0] awa = 16'h0000, ara = 16'h0000;
    logic [31:0] wd = 32'h0000_0000, rdata;
    logic        awr, wrd, bv, arr, rv, int5, crst, pdm, irq;
    logic [1:0]  bresp, rresp;
    int          err_total = 0, samples_checked = 0, cyc = 0, resets, rises;
    rtw_top #(.FAST_DIV_CYC(8), .WDOG_CYC(64)) i_rtw_top (.i_clk(i_clk), .i_rst(i_rst),
        .i_lsosc(i_lsosc), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
        .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'h1), .o_bvalid(bv), .i_bready(bre),
        .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
        .i_rready(rre), .o_rdata(rdata), .o_rresp(rresp), .o_ext_int5(int5),
        .o_chip_reset(crst), .o_powerdown_mux(pdm), .o_irq(irq));
    rtw_core_model i_rtw_core_model (.i_clk(i_clk), .i_ext_int5(int5), .i_chip_reset(crst),
        .o_irq_rises(rises), .o_resets(resets));
    initial forever #2 i_clk = ~i_clk;
    always @(posedge i_clk) i_lsosc <= ~i_lsosc;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge i_clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= {24'h0, d};
        bre <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv && n < 50);
        bre <= 1'b0;
        chk("bvalid", 32'h1, {31'h0, bv});
        chk($sformatf("bresp %h", a), 32'h0, {30'h0, bresp});
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] rs = 2'h0);
        int n = 0;
        @(posedge i_clk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 50);
        rre <= 1'b0;
        chk("rvalid", 32'h1, {31'h0, rv});
        chk($sformatf("rresp %h", a), {30'h0, rs}, {30'h0, rresp});
        if (rs === 2'h0) chk($sformatf("rdata %h", a), exp, rdata);
    endtask
    task automatic wait_irq();
        int n = 0;
        while (!int5 && n < 40000) begin
            @(posedge i_clk);
            n++;
        end
        chk("ext_int5", 32'h1, {31'h0, int5});
    endtask
    task automatic stage(input logic [7:0] c0, input logic [7:0] t2);
        wr(rtw_pkg::OFF_CNT0, c0);
        for (int k = 0; k < 3; k++) wr(rtw_pkg::OFF_ACC2 + 16'(4 * k), 8'hff);
        wr(rtw_pkg::OFF_TRIM2, t2);
        wr(rtw_pkg::OFF_TRIM0, 8'h01);
        rd(rtw_pkg::OFF_CNT0, {24'h0, c0});
        wr(rtw_pkg::OFF_CTL, 8'h34);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(rtw_pkg::OFF_CTL, 32'h0);
        rd(rtw_pkg::OFF_INT5, 32'h0);
        rd(16'h0000, 32'h0, rtw_pkg::RESP_DECERR);
        for (int k = 0; k < 8; k++) begin
            wr(rtw_pkg::OFF_CTL, {3'h0, k[1:0], k[2:0]});
            rd(rtw_pkg::OFF_CTL, {27'h0, k[1:0], k[2:0]});
        end
        $display("test control fields done");
        stage(8'h10, 8'h00);
        wr(rtw_pkg::OFF_INT5, 8'ha0);
        rd(rtw_pkg::OFF_LIVE_CNT, 32'h10);
        wait_irq();
        rd(rtw_pkg::OFF_LIVE_CNT, 32'h12);
        chk("irq rises", 32'h1, rises);
        repeat (72) @(posedge i_clk);
        chk("resets", 32'h1, resets);
        rd(rtw_pkg::OFF_INT5, 32'hb0);
        rd(rtw_pkg::OFF_INT5, 32'ha0);
        chk("powerdown_mux_select", 32'h1, {31'h0, pdm});
        $display("test positive trim and watchdog done");
        rd(rtw_pkg::OFF_IRQ_STAT, 32'h7);
        wr(rtw_pkg::OFF_IRQ_MASK, 8'h04);
        repeat (2) @(posedge i_clk);
        chk("irq masked on", 32'h1, {31'h0, irq});
        wr(rtw_pkg::OFF_IRQ_STAT, 8'h07);
        repeat (2) @(posedge i_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test status done");
        stage(8'h20, 8'h80);
        wait_irq();
        wr(rtw_pkg::OFF_INT5, 8'h80);
        repeat (72) @(posedge i_clk);
        chk("resets", 32'h1, resets);
        wr(rtw_pkg::OFF_INT5, 8'ha0);
        rd(rtw_pkg::OFF_INT5, 32'hb0);
        rd(rtw_pkg::OFF_LIVE_CNT, 32'h20);
        repeat (72) @(posedge i_clk);
        chk("resets", 32'h1, resets);
        $display("test negative trim and service done");
        wr(rtw_pkg::OFF_CFG, 8'h01);
        wr(rtw_pkg::OFF_TRIM2, 8'h00);
        wr(rtw_pkg::OFF_TRIM1, 8'h06);
        wr(rtw_pkg::OFF_TRIM0, 8'hfd);
        wr(rtw_pkg::OFF_CTL, 8'h20);
        repeat (12) @(posedge i_clk);
        rd(rtw_pkg::OFF_CTL, 32'h0);
        $display("test fast source trim done");
        close_out();
    end
endmodule
bind rtw_top rtw_checker #(.WDOG_CYC(WDOG_CYC)) i_rtw_checker (.i_clk(i_clk), .i_rst(i_rst),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_ext_int5(o_ext_int5),
    .o_chip_reset(o_chip_reset));
`default_nettype wire

//--- hdl/rtw_top.sv
// Real-time clock with trim compensation and hardware watchdog.
// Assumes an AXI4-Lite master, a level 32 kHz oscillator input
// synchronous to i_clk, and system reset logic taking o_chip_reset.
`timescale 1ns/10ps
`default_nettype none

module rtw_top #(
    parameter int FAST_DIV_CYC = rtw_pkg::FAST_DIV_CYC,
    parameter int WDOG_CYC     = rtw_pkg::WDOG_CYC
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_lsosc,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [rtw_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    input  wire logic [31:0]                i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    output logic [1:0]                      o_bresp,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    input  wire logic [rtw_pkg::ADDR_W-1:0] i_araddr,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    output logic [31:0]                     o_rdata,
    output logic [1:0]                      o_rresp,
    output logic                            o_ext_int5,
    output logic                            o_chip_reset,
    output logic                            o_powerdown_mux,
    output logic                            o_irq
);

    localparam int FDW = $clog2(FAST_DIV_CYC);
    localparam int WDW = $clog2(WDOG_CYC);
    localparam int HTW = $clog2(rtw_pkg::HALF_TICKS);

    // ==========================================================
    // Functions
    function automatic logic [3:0] period_mask(input logic [1:0] sel);
        logic [3:0] m;
        m = 4'h1;
        if (sel == 2'b10) begin
            m = 4'h0;
        end else if (sel == 2'b11) begin
            m = 4'h3;
        end
        return m;
    endfunction

    function automatic logic [3:0] interval_mask(input logic [2:0] sel);
        logic [3:0] m;
        m = 4'h1;
        if (sel[2]) begin
            m = period_mask({1'b1, sel[1] | sel[0]});
            if (sel[1:0] == 2'b10) begin
                m = 4'h7;
            end else if (sel[1:0] == 2'b11) begin
                m = 4'hf;
            end
        end
        return m;
    endfunction

    // ==========================================================
    // Declarations
    logic                       awready_reg, wready_reg, bvalid_reg;
    logic                       arready_reg, rvalid_reg;
    logic [1:0]                 bresp_reg, rresp_reg;
    logic [31:0]                rdata_reg;
    logic [rtw_pkg::ADDR_W-1:0] awaddr_reg;
    logic [7:0]                 wbyte_reg;
    logic                       wlane_reg;
    logic                       do_write, wr_en, rd_take, rd_int5;
    logic [31:0]                rd_data;
    logic                       rd_ok, wr_ok;
    rtw_pkg::rtw_ctl_s          ctl_reg;
    logic                       powerdown_mux_select_reg, ien_reg, flag_reg, fastsrc_reg;
    logic [31:0]                stage_cnt_reg;
    logic [23:0]                stage_acc_reg, stage_trim_reg;
    logic [31:0]                cnt_reg;
    logic [23:0]                acc_reg, trim_reg;
    logic [rtw_pkg::IST_W-1:0]  ist_reg, imask_reg, ist_evt;
    logic                       osc_prev_reg, tick32_reg;
    logic [FDW-1:0]             fdiv_reg;
    logic [HTW-1:0]             hdiv_reg;
    logic [3:0]                 halves_reg;
    logic                       half_mark, cnt_tick, int_tick;
    logic [3:0]                 halves_next;
    logic [24:0]                acc_sum;
    logic [WDW-1:0]             wd_cnt_reg;
    rtw_pkg::rtw_wd_e           wd_state_reg;
    logic                       wd_fire;
    logic                       ext_int5_reg, chip_reset_reg, irq_reg;

    assign o_awready       = awready_reg;
    assign o_wready        = wready_reg;
    assign o_bvalid        = bvalid_reg;
    assign o_bresp         = bresp_reg;
    assign o_arready       = arready_reg;
    assign o_rvalid        = rvalid_reg;
    assign o_rdata         = rdata_reg;
    assign o_rresp         = rresp_reg;
    assign o_ext_int5      = ext_int5_reg;
    assign o_chip_reset    = chip_reset_reg;
    assign o_powerdown_mux = powerdown_mux_select_reg;
    assign o_irq           = irq_reg;

    // ==========================================================
    // AXI4-Lite write channel
    assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_en    = do_write && wlane_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= rtw_pkg::RESP_OKAY;
            awaddr_reg  <= '0;
            wbyte_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
        end else begin
            if (i_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                awaddr_reg  <= i_awaddr;
            end
            if (i_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wbyte_reg  <= i_wdata[7:0];
                wlane_reg  <= i_wstrb[0];
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? rtw_pkg::RESP_OKAY : rtw_pkg::RESP_DECERR;
            end
            if (bvalid_reg && i_bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    always_comb begin
        case (awaddr_reg)
            rtw_pkg::OFF_INT5, rtw_pkg::OFF_CTL, rtw_pkg::OFF_CNT3, rtw_pkg::OFF_CNT2,
            rtw_pkg::OFF_CNT1, rtw_pkg::OFF_CNT0, rtw_pkg::OFF_ACC2, rtw_pkg::OFF_ACC1,
            rtw_pkg::OFF_ACC0, rtw_pkg::OFF_TRIM2, rtw_pkg::OFF_TRIM1, rtw_pkg::OFF_TRIM0,
            rtw_pkg::OFF_IRQ_STAT, rtw_pkg::OFF_IRQ_MASK, rtw_pkg::OFF_LIVE_CNT,
            rtw_pkg::OFF_CFG: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign rd_take = i_arvalid && arready_reg;
    assign rd_int5 = rd_take && (i_araddr == rtw_pkg::OFF_INT5);

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        case (i_araddr)
            rtw_pkg::OFF_INT5: begin
                rd_data[rtw_pkg::INT5_POWERDOWN_MUX_SELECT] = powerdown_mux_select_reg;
                rd_data[rtw_pkg::INT5_IEN]   = ien_reg;
                rd_data[rtw_pkg::INT5_FLAG]  = flag_reg;
            end
            rtw_pkg::OFF_CTL:      rd_data[7:0] = ctl_reg;
            rtw_pkg::OFF_CNT3:     rd_data[7:0] = stage_cnt_reg[31:24];
            rtw_pkg::OFF_CNT2:     rd_data[7:0] = stage_cnt_reg[23:16];
            rtw_pkg::OFF_CNT1:     rd_data[7:0] = stage_cnt_reg[15:8];
            rtw_pkg::OFF_CNT0:     rd_data[7:0] = stage_cnt_reg[7:0];
            rtw_pkg::OFF_ACC2:     rd_data[7:0] = stage_acc_reg[23:16];
            rtw_pkg::OFF_ACC1:     rd_data[7:0] = stage_acc_reg[15:8];
            rtw_pkg::OFF_ACC0:     rd_data[7:0] = stage_acc_reg[7:0];
            rtw_pkg::OFF_TRIM2:    rd_data[7:0] = stage_trim_reg[23:16];
            rtw_pkg::OFF_TRIM1:    rd_data[7:0] = stage_trim_reg[15:8];
            rtw_pkg::OFF_TRIM0:    rd_data[7:0] = stage_trim_reg[7:0];
            rtw_pkg::OFF_IRQ_STAT: rd_data[rtw_pkg::IST_W-1:0] = ist_reg;
            rtw_pkg::OFF_IRQ_MASK: rd_data[rtw_pkg::IST_W-1:0] = imask_reg;
            rtw_pkg::OFF_LIVE_CNT: rd_data = cnt_reg;
            rtw_pkg::OFF_CFG:      rd_data[rtw_pkg::CFG_FASTSRC] = fastsrc_reg;
            default:               rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= rtw_pkg::RESP_OKAY;
        end else if (rd_take) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_data;
            rresp_reg   <= rd_ok ? rtw_pkg::RESP_OKAY : rtw_pkg::RESP_DECERR;
        end else if (rvalid_reg && i_rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Control, configuration and staging registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctl_reg <= rtw_pkg::CTL_RST;
        end else if (wr_en && awaddr_reg == rtw_pkg::OFF_CTL) begin
            ctl_reg <= {2'b00, wbyte_reg[5:0]};
        end else if (tick32_reg && ctl_reg.load) begin
            ctl_reg.load <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            powerdown_mux_select_reg   <= rtw_pkg::INT5_RST[rtw_pkg::INT5_POWERDOWN_MUX_SELECT];
            ien_reg     <= rtw_pkg::INT5_RST[rtw_pkg::INT5_IEN];
            fastsrc_reg <= 1'b0;
            imask_reg   <= '0;
        end else if (wr_en) begin
            if (awaddr_reg == rtw_pkg::OFF_INT5) begin
                powerdown_mux_select_reg <= wbyte_reg[rtw_pkg::INT5_POWERDOWN_MUX_SELECT];
                ien_reg   <= wbyte_reg[rtw_pkg::INT5_IEN];
            end
            if (awaddr_reg == rtw_pkg::OFF_CFG) begin
                fastsrc_reg <= wbyte_reg[rtw_pkg::CFG_FASTSRC];
            end
            if (awaddr_reg == rtw_pkg::OFF_IRQ_MASK) begin
                imask_reg <= wbyte_reg[rtw_pkg::IST_W-1:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage_cnt_reg  <= {4{rtw_pkg::STAGE_RST}};
            stage_acc_reg  <= {3{rtw_pkg::STAGE_RST}};
            stage_trim_reg <= {3{rtw_pkg::STAGE_RST}};
        end else if (wr_en) begin
            case (awaddr_reg)
                rtw_pkg::OFF_CNT3:  stage_cnt_reg[31:24]  <= wbyte_reg;
                rtw_pkg::OFF_CNT2:  stage_cnt_reg[23:16]  <= wbyte_reg;
                rtw_pkg::OFF_CNT1:  stage_cnt_reg[15:8]   <= wbyte_reg;
                rtw_pkg::OFF_CNT0:  stage_cnt_reg[7:0]    <= wbyte_reg;
                rtw_pkg::OFF_ACC2:  stage_acc_reg[23:16]  <= wbyte_reg;
                rtw_pkg::OFF_ACC1:  stage_acc_reg[15:8]   <= wbyte_reg;
                rtw_pkg::OFF_ACC0:  stage_acc_reg[7:0]    <= wbyte_reg;
                rtw_pkg::OFF_TRIM2: stage_trim_reg[23:16] <= wbyte_reg;
                rtw_pkg::OFF_TRIM1: stage_trim_reg[15:8]  <= wbyte_reg;
                rtw_pkg::OFF_TRIM0: stage_trim_reg[7:0]   <= wbyte_reg;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // 32 kHz tick source and half-second marks
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            osc_prev_reg <= 1'b0;
            fdiv_reg     <= '0;
            tick32_reg   <= 1'b0;
        end else begin
            osc_prev_reg <= i_lsosc;
            if (fdiv_reg == FDW'(FAST_DIV_CYC - 1)) begin
                fdiv_reg <= '0;
            end else begin
                fdiv_reg <= fdiv_reg + 1'b1;
            end
            if (fastsrc_reg) begin
                tick32_reg <= (fdiv_reg == FDW'(FAST_DIV_CYC - 1));
            end else begin
                tick32_reg <= i_lsosc && !osc_prev_reg;
            end
        end
    end

    assign half_mark   = tick32_reg && (hdiv_reg == HTW'(rtw_pkg::HALF_TICKS - 1));
    assign halves_next = halves_reg + 1'b1;
    assign cnt_tick    = half_mark && ((halves_next & period_mask(ctl_reg.period)) == 4'h0);
    assign int_tick    = half_mark && ((halves_next & interval_mask(ctl_reg.interval)) == 4'h0);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hdiv_reg   <= '0;
            halves_reg <= 4'h0;
        end else if (tick32_reg) begin
            hdiv_reg <= hdiv_reg + 1'b1;
            if (half_mark) begin
                halves_reg <= halves_next;
            end
        end
    end

    // ==========================================================
    // Time counter, accumulator and trim
    assign acc_sum = {1'b0, acc_reg} + {2'b00, trim_reg[rtw_pkg::TRIM_SIGN-1:0]};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg  <= 32'h0000_0000;
            acc_reg  <= 24'h00_0000;
            trim_reg <= 24'h00_0000;
        end else if (tick32_reg && ctl_reg.load) begin
            cnt_reg  <= stage_cnt_reg;
            acc_reg  <= stage_acc_reg;
            trim_reg <= stage_trim_reg;
        end else if (cnt_tick) begin
            acc_reg <= acc_sum[23:0];
            if (!acc_sum[24]) begin
                cnt_reg <= cnt_reg + 32'h0000_0001;
            end else if (!trim_reg[rtw_pkg::TRIM_SIGN]) begin
                cnt_reg <= cnt_reg + 32'h0000_0002;
            end
        end
    end

    // ==========================================================
    // Interrupt flag and external interrupt 5
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_reg <= rtw_pkg::INT5_RST[rtw_pkg::INT5_FLAG];
        end else if (int_tick) begin
            flag_reg <= 1'b1;
        end else if (rd_int5) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_int5_reg <= 1'b0;
        end else begin
            ext_int5_reg <= flag_reg && ien_reg;
        end
    end

    // ==========================================================
    // Hardware watchdog
    assign wd_fire = (wd_state_reg == rtw_pkg::WD_RUN) && (wd_cnt_reg == WDW'(WDOG_CYC - 1));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wd_state_reg   <= rtw_pkg::WD_IDLE;
            wd_cnt_reg     <= '0;
            chip_reset_reg <= 1'b0;
        end else begin
            chip_reset_reg <= wd_fire;
            if (!ien_reg || !flag_reg) begin
                wd_state_reg <= rtw_pkg::WD_IDLE;
                wd_cnt_reg   <= '0;
            end else begin
                case (wd_state_reg)
                    rtw_pkg::WD_IDLE: begin
                        wd_state_reg <= rtw_pkg::WD_RUN;
                        wd_cnt_reg   <= '0;
                    end
                    rtw_pkg::WD_RUN: begin
                        if (wd_fire) begin
                            wd_state_reg <= rtw_pkg::WD_FIRED;
                        end else begin
                            wd_cnt_reg <= wd_cnt_reg + 1'b1;
                        end
                    end
                    rtw_pkg::WD_FIRED: wd_state_reg <= rtw_pkg::WD_FIRED;
                    default:           wd_state_reg <= rtw_pkg::WD_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Sticky status, mask and interrupt output
    always_comb begin
        ist_evt                        = '0;
        ist_evt[rtw_pkg::IST_INTERVAL] = int_tick;
        ist_evt[rtw_pkg::IST_CARRY]    = cnt_tick && acc_sum[24] && !ctl_reg.load;
        ist_evt[rtw_pkg::IST_WDOG]     = wd_fire;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ist_reg <= '0;
        end else if (wr_en && awaddr_reg == rtw_pkg::OFF_IRQ_STAT) begin
            ist_reg <= (ist_reg & ~wbyte_reg[rtw_pkg::IST_W-1:0]) | ist_evt;
        end else begin
            ist_reg <= ist_reg | ist_evt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(ist_reg & imask_reg);
        end
    end

endmodule

`default_nettype wire

//--- inc/rtw_pkg.sv
// Package for the real-time clock with trim and hardware watchdog.
// Assumes a 250 MHz system clock and an AXI4-Lite register bus.
package rtw_pkg;

    // ==========================================================
    // Bus geometry and answers
    localparam int          ADDR_W       = 16;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

    // ==========================================================
    // Register byte addresses
    localparam logic [15:0] OFF_INT5     = 16'hff94;
    localparam logic [15:0] OFF_CTL      = 16'hffb0;
    localparam logic [15:0] OFF_CNT3     = 16'hffb4;
    localparam logic [15:0] OFF_CNT2     = 16'hffb8;
    localparam logic [15:0] OFF_CNT1     = 16'hffbc;
    localparam logic [15:0] OFF_CNT0     = 16'hffc0;
    localparam logic [15:0] OFF_ACC2     = 16'hffc4;
    localparam logic [15:0] OFF_ACC1     = 16'hffc8;
    localparam logic [15:0] OFF_ACC0     = 16'hffcc;
    localparam logic [15:0] OFF_TRIM2    = 16'hffd0;
    localparam logic [15:0] OFF_TRIM1    = 16'hffd4;
    localparam logic [15:0] OFF_TRIM0    = 16'hffd8;
    localparam logic [15:0] OFF_IRQ_STAT = 16'hffdc;
    localparam logic [15:0] OFF_IRQ_MASK = 16'hffe0;
    localparam logic [15:0] OFF_LIVE_CNT = 16'hffe4;
    localparam logic [15:0] OFF_CFG      = 16'hffe8;

    // ==========================================================
    // Field positions and reset values
    localparam int          INT5_POWERDOWN_MUX_SELECT   = 7;
    localparam int          INT5_IEN     = 5;
    localparam int          INT5_FLAG    = 4;
    localparam int          CFG_FASTSRC  = 0;
    localparam int          TRIM_SIGN    = 23;
    localparam int          IST_INTERVAL = 0;
    localparam int          IST_CARRY    = 1;
    localparam int          IST_WDOG     = 2;
    localparam int          IST_W        = 3;
    localparam logic [7:0]  CTL_RST      = 8'h00;
    localparam logic [7:0]  INT5_RST     = 8'h00;
    localparam logic [7:0]  STAGE_RST    = 8'h00;

    // ==========================================================
    // Timing
    localparam longint      CLK_HZ       = 64'd250_000_000;
    localparam longint      MCLK_HZ      = 64'd96_000_000;
    localparam longint      FAST_DIV     = 64'd2930;
    localparam int          FAST_DIV_CYC = int'((CLK_HZ * FAST_DIV) / MCLK_HZ);
    localparam int          OSC_HZ       = 32768;
    localparam int          HALF_TICKS   = OSC_HZ / 2;
    localparam longint      WDOG_MS      = 64'd500;
    localparam int          WDOG_CYC     = int'((CLK_HZ * WDOG_MS) / 64'd1000);

    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] unused;
        logic       load;
        logic [1:0] period;
        logic [2:0] interval;
    } rtw_ctl_s;

    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,
        WD_RUN   = 2'b01,
        WD_FIRED = 2'b10
    } rtw_wd_e;

endpackage
